// >>> hdl/htr_pkg.sv
// constants for the hdlc timeslot routing block
package htr_pkg;
  localparam int unsigned HTR_DATA_W = 8;
  localparam int unsigned HTR_ADDR_W = 8;
  localparam int unsigned HTR_SLOT_W = 5;
  localparam int unsigned HTR_POS_W = 3;
  localparam int unsigned HTR_SA_W = 5;
  localparam int unsigned HTR_SLOTS = 32;
  // register offsets
  localparam logic [7:0] HTR_RX_LINK_ROUTING_CONTROL_OFS = 8'hb8;
  localparam logic [7:0] HTR_RX_CHANNEL_BIT_SUPPRESS_OFS = 8'hb9;
  localparam logic [7:0] HTR_TX_LINK_ROUTING_CONTROL_OFS = 8'hba;
  localparam logic [7:0] HTR_TX_CHANNEL_BIT_SUPPRESS_OFS = 8'hbb;
  // values after reset
  localparam logic [7:0] HTR_RX_LINK_ROUTING_CONTROL_RST = 8'h00;
  localparam logic [7:0] HTR_RX_CHANNEL_BIT_SUPPRESS_RST = 8'h00;
  localparam logic [7:0] HTR_TX_LINK_ROUTING_CONTROL_RST = 8'h00;
  localparam logic [7:0] HTR_TX_CHANNEL_BIT_SUPPRESS_RST = 8'h00;
  localparam logic [7:0] HTR_UNMAPPED_READ = 8'h00;
  // field positions in both link routing control registers
  localparam int unsigned HTR_ENABLE_BIT = 7;
  localparam int unsigned HTR_SPARE_OR_SLOT_BIT = 6;
  localparam int unsigned HTR_CHOICE_MODE_BIT = 5;
  localparam int unsigned HTR_SLOT_NUMBER_LSB = 0;
  // sa4..sa8 sit in bit numbers 4..8 of slot 0 of the non-alignment frame
  localparam logic [4:0] HTR_SA_SLOT = 5'h00;
  localparam logic [2:0] HTR_SA_FIRST_POS = 3'h3;
endpackage

// >>> hdl/htr_slot_select.sv
// decides whether one bit position of the e1 frame belongs to the hdlc link
`timescale 1ns/1ps
`default_nettype none
module htr_slot_select
  import htr_pkg::*;
(
  input wire logic enable,
  input wire logic spare_or_slot_select,
  input wire logic slot_choice_mode,
  input wire logic [htr_pkg::HTR_SLOT_W-1:0] slot_number,
  input wire logic [htr_pkg::HTR_SLOTS-1:0] channel_block_map,
  input wire logic [htr_pkg::HTR_DATA_W-1:0] bit_suppress,
  input wire logic [htr_pkg::HTR_SA_W-1:0] spare_enable,
  input wire logic [htr_pkg::HTR_SLOT_W-1:0] slot,
  input wire logic [htr_pkg::HTR_POS_W-1:0] bit_pos,
  input wire logic nfas_frame,
  output logic hit
);
  import htr_pkg::*;

  // bit_pos 3..7 is sa4..sa8; select bit 4 is sa4, select bit 0 is sa8
  function automatic logic spare_hit(input logic [HTR_SA_W-1:0] en,
                                     input logic [HTR_POS_W-1:0] pos);
    logic [HTR_POS_W-1:0] idx;
    idx = 3'h7 - pos;
    spare_hit = (pos >= HTR_SA_FIRST_POS) && en[idx];
  endfunction

  logic in_spare;
  logic in_slot;

  always_comb begin
    in_spare = (slot == HTR_SA_SLOT) && nfas_frame && spare_hit(spare_enable, bit_pos);
    if (slot_choice_mode) begin
      in_slot = channel_block_map[slot];
    end else begin
      in_slot = (slot == slot_number);
    end
    // suppress bit n maps to ds0 bit n+1, i.e. bit_pos n
    in_slot = in_slot && !bit_suppress[bit_pos];
    // select bit only counts while enabled
    hit = enable && (spare_or_slot_select ? in_slot : in_spare);
  end
endmodule
`default_nettype wire

// >>> hdl/htr_top.sv
// routing of hdlc bits between the e1 frame streams and the hdlc controller
`timescale 1ns/1ps
`default_nettype none
module htr_top
  import htr_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [htr_pkg::HTR_ADDR_W-1:0] reg_addr,
  input wire logic [htr_pkg::HTR_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [htr_pkg::HTR_DATA_W-1:0] reg_rdata,
  input wire logic [htr_pkg::HTR_SA_W-1:0] rx_control_two_sa,
  input wire logic [htr_pkg::HTR_SLOTS-1:0] rx_channel_block_map,
  input wire logic [htr_pkg::HTR_SLOTS-1:0] tx_channel_block_map,
  input wire logic tx_bit_strobe,
  input wire logic [htr_pkg::HTR_SLOT_W-1:0] tx_slot,
  input wire logic [htr_pkg::HTR_POS_W-1:0] tx_bit_pos,
  input wire logic tx_nfas_frame,
  input wire logic tx_framer_bit,
  input wire logic tx_hdlc_bit,
  output logic tx_out_bit,
  output logic tx_out_valid,
  output logic tx_hdlc_take,
  input wire logic rx_bit_strobe,
  input wire logic [htr_pkg::HTR_SLOT_W-1:0] rx_slot,
  input wire logic [htr_pkg::HTR_POS_W-1:0] rx_bit_pos,
  input wire logic rx_nfas_frame,
  input wire logic rx_line_bit,
  output logic rx_hdlc_bit,
  output logic rx_hdlc_valid
);
  import htr_pkg::*;

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // register port
  logic [7:0] rx_link_routing_control;
  logic [7:0] rx_channel_bit_suppress;
  logic [7:0] tx_link_routing_control;
  logic [7:0] tx_channel_bit_suppress;
  logic [7:0] next_rx_link_routing_control;
  logic [7:0] next_rx_channel_bit_suppress;
  logic [7:0] next_tx_link_routing_control;
  logic [7:0] next_tx_channel_bit_suppress;
  logic [7:0] next_reg_rdata;

  always_comb begin
    next_rx_link_routing_control = rx_link_routing_control;
    next_rx_channel_bit_suppress = rx_channel_bit_suppress;
    next_tx_link_routing_control = tx_link_routing_control;
    next_tx_channel_bit_suppress = tx_channel_bit_suppress;
    if (reg_wr) begin
      case (reg_addr)
        HTR_RX_LINK_ROUTING_CONTROL_OFS: next_rx_link_routing_control = reg_wdata;
        HTR_RX_CHANNEL_BIT_SUPPRESS_OFS: next_rx_channel_bit_suppress = reg_wdata;
        HTR_TX_LINK_ROUTING_CONTROL_OFS: next_tx_link_routing_control = reg_wdata;
        HTR_TX_CHANNEL_BIT_SUPPRESS_OFS: next_tx_channel_bit_suppress = reg_wdata;
        default: begin
        end
      endcase
    end
    // read data holds until the next read so a slow host can sample it
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        HTR_RX_LINK_ROUTING_CONTROL_OFS: next_reg_rdata = rx_link_routing_control;
        HTR_RX_CHANNEL_BIT_SUPPRESS_OFS: next_reg_rdata = rx_channel_bit_suppress;
        HTR_TX_LINK_ROUTING_CONTROL_OFS: next_reg_rdata = tx_link_routing_control;
        HTR_TX_CHANNEL_BIT_SUPPRESS_OFS: next_reg_rdata = tx_channel_bit_suppress;
        default: next_reg_rdata = HTR_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_link_routing_control <= HTR_RX_LINK_ROUTING_CONTROL_RST;
      rx_channel_bit_suppress <= HTR_RX_CHANNEL_BIT_SUPPRESS_RST;
      tx_link_routing_control <= HTR_TX_LINK_ROUTING_CONTROL_RST;
      tx_channel_bit_suppress <= HTR_TX_CHANNEL_BIT_SUPPRESS_RST;
      reg_rdata <= HTR_UNMAPPED_READ;
    end else begin
      rx_link_routing_control <= next_rx_link_routing_control;
      rx_channel_bit_suppress <= next_rx_channel_bit_suppress;
      tx_link_routing_control <= next_tx_link_routing_control;
      tx_channel_bit_suppress <= next_tx_channel_bit_suppress;
      reg_rdata <= next_reg_rdata;
    end
  end

  // transmit selection
  logic tx_hit;
  htr_slot_select u_tx_select (
    .enable(tx_link_routing_control[HTR_ENABLE_BIT]),
    .spare_or_slot_select(tx_link_routing_control[HTR_SPARE_OR_SLOT_BIT]),
    .slot_choice_mode(tx_link_routing_control[HTR_CHOICE_MODE_BIT]),
    .slot_number(tx_link_routing_control[HTR_SLOT_NUMBER_LSB +: HTR_SLOT_W]),
    .channel_block_map(tx_channel_block_map),
    .bit_suppress(tx_channel_bit_suppress),
    .spare_enable(tx_link_routing_control[HTR_SLOT_NUMBER_LSB +: HTR_SA_W]),
    .slot(tx_slot),
    .bit_pos(tx_bit_pos),
    .nfas_frame(tx_nfas_frame),
    .hit(tx_hit)
  );

  // receive source: rx_control_two sa bits or the receive routing register
  logic rx_source;
  logic rx_hit;
  assign rx_source = rx_link_routing_control[HTR_ENABLE_BIT];
  htr_slot_select u_rx_select (
    .enable(1'b1),
    .spare_or_slot_select(rx_source && rx_link_routing_control[HTR_SPARE_OR_SLOT_BIT]),
    .slot_choice_mode(rx_link_routing_control[HTR_CHOICE_MODE_BIT]),
    .slot_number(rx_link_routing_control[HTR_SLOT_NUMBER_LSB +: HTR_SLOT_W]),
    .channel_block_map(rx_channel_block_map),
    .bit_suppress(rx_channel_bit_suppress),
    .spare_enable(rx_source ? rx_link_routing_control[HTR_SLOT_NUMBER_LSB +: HTR_SA_W]
                            : rx_control_two_sa),
    .slot(rx_slot),
    .bit_pos(rx_bit_pos),
    .nfas_frame(rx_nfas_frame),
    .hit(rx_hit)
  );

  // bit datapath, one cycle from strobe to outputs
  logic next_tx_out_bit;
  logic next_tx_out_valid;
  logic next_tx_hdlc_take;
  logic next_rx_hdlc_bit;
  logic next_rx_hdlc_valid;

  always_comb begin
    next_tx_out_valid = tx_bit_strobe;
    next_tx_hdlc_take = tx_bit_strobe && tx_hit;
    next_tx_out_bit = tx_out_bit;
    if (tx_bit_strobe) begin
      next_tx_out_bit = tx_hit ? tx_hdlc_bit : tx_framer_bit;
    end
    // skipped positions give no valid, so the receiver only sees routed bits
    next_rx_hdlc_valid = rx_bit_strobe && rx_hit;
    next_rx_hdlc_bit = rx_hdlc_bit;
    if (next_rx_hdlc_valid) begin
      next_rx_hdlc_bit = rx_line_bit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_bit <= 1'b0;
      tx_out_valid <= 1'b0;
      tx_hdlc_take <= 1'b0;
      rx_hdlc_bit <= 1'b0;
      rx_hdlc_valid <= 1'b0;
    end else begin
      tx_out_bit <= next_tx_out_bit;
      tx_out_valid <= next_tx_out_valid;
      tx_hdlc_take <= next_tx_hdlc_take;
      rx_hdlc_bit <= next_rx_hdlc_bit;
      rx_hdlc_valid <= next_rx_hdlc_valid;
    end
  end

  // checks
  // outputs are registered, so every check except AST_RX_HOLD_BIT looks one edge past the cycle its antecedent samples
  AST_TX_DISABLED: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_bit_strobe && !tx_link_routing_control[7])
    |=> (!tx_hdlc_take && tx_out_valid && tx_out_bit == $past(tx_framer_bit)))
    else $error("hdlc data inserted while transmit disabled");

  AST_TX_SA_ROUTE: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_bit_strobe && tx_link_routing_control[7:6] == 2'b10 && tx_slot == 5'h00
     && tx_nfas_frame && tx_bit_pos == 3'h3 && tx_link_routing_control[4])
    |=> (tx_hdlc_take && tx_out_bit == $past(tx_hdlc_bit)))
    else $error("sa4 not taken from hdlc");

  AST_TX_SINGLE_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_bit_strobe && tx_link_routing_control[7:5] == 3'b110
     && tx_slot == tx_link_routing_control[4:0] && !tx_channel_bit_suppress[tx_bit_pos])
    |=> tx_hdlc_take)
    else $error("selected transmit channel not used");

  AST_TX_OTHER_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_bit_strobe && tx_link_routing_control[6:5] == 2'b10
     && tx_slot != tx_link_routing_control[4:0])
    |=> (!tx_hdlc_take && tx_out_bit == $past(tx_framer_bit)))
    else $error("unselected transmit channel carried hdlc data");

  AST_TX_BLOCK_MAP: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_bit_strobe && tx_link_routing_control[7:5] == 3'b111
     && tx_channel_block_map[tx_slot] && !tx_channel_bit_suppress[tx_bit_pos])
    |=> tx_hdlc_take)
    else $error("block-mapped transmit channel not used");

  AST_TX_SUPPRESS: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_bit_strobe && tx_link_routing_control[6] && tx_channel_bit_suppress[tx_bit_pos])
    |=> (!tx_hdlc_take && tx_out_bit == $past(tx_framer_bit)))
    else $error("suppressed transmit bit carried hdlc data");

  AST_RX_SUPPRESS: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_bit_strobe && rx_link_routing_control[7:6] == 2'b11
     && rx_channel_bit_suppress[rx_bit_pos])
    |=> !rx_hdlc_valid)
    else $error("suppressed receive bit passed to hdlc");

  AST_RX_SA_DEFAULT: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_bit_strobe && !rx_link_routing_control[7] && rx_slot == 5'h00 && rx_nfas_frame
     && rx_bit_pos == 3'h7 && rx_control_two_sa[0])
    |=> (rx_hdlc_valid && rx_hdlc_bit == $past(rx_line_bit)))
    else $error("sa8 from rx_control_two not received");

  AST_RX_SINGLE_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_bit_strobe && rx_link_routing_control[7:5] == 3'b110
     && rx_slot == rx_link_routing_control[4:0] && !rx_channel_bit_suppress[rx_bit_pos])
    |=> (rx_hdlc_valid && rx_hdlc_bit == $past(rx_line_bit)))
    else $error("selected receive channel not passed to hdlc");

  AST_RX_OTHER_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_bit_strobe && rx_link_routing_control[7:5] == 3'b110
     && rx_slot != rx_link_routing_control[4:0])
    |=> !rx_hdlc_valid)
    else $error("unselected receive channel passed to hdlc");

  AST_RX_BLOCK_MAP: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_bit_strobe && rx_link_routing_control[7:5] == 3'b111
     && rx_channel_block_map[rx_slot] && !rx_channel_bit_suppress[rx_bit_pos])
    |=> (rx_hdlc_valid && rx_hdlc_bit == $past(rx_line_bit)))
    else $error("block-mapped receive channel not passed to hdlc");

  AST_RX_SA_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_bit_strobe && !rx_link_routing_control[7] && rx_slot == 5'h00 && rx_nfas_frame
     && rx_bit_pos == 3'h3 && !rx_control_two_sa[4])
    |=> !rx_hdlc_valid)
    else $error("disabled sa4 passed to hdlc");

  AST_RX_SA_ROUTE: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_bit_strobe && rx_link_routing_control[7:6] == 2'b10 && rx_slot == 5'h00
     && rx_nfas_frame && rx_bit_pos == 3'h3 && rx_link_routing_control[4])
    |=> (rx_hdlc_valid && rx_hdlc_bit == $past(rx_line_bit)))
    else $error("sa4 not passed to hdlc");

  // the receiver counts bits on valid alone, so a stray pulse would corrupt a frame
  AST_RX_NO_STRAY: assert property (@(posedge clock) disable iff (!rst_n)
    !rx_bit_strobe |=> !rx_hdlc_valid)
    else $error("receive valid without a strobe");

  AST_RX_HOLD_BIT: assert property (@(posedge clock) disable iff (!rst_n)
    !rx_hdlc_valid |-> $stable(rx_hdlc_bit))
    else $error("receive bit changed without valid");

  AST_TX_ONE_PER_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
    tx_bit_strobe |=> tx_out_valid)
    else $error("transmit bit not passed on");

  AST_TX_NO_STRAY: assert property (@(posedge clock) disable iff (!rst_n)
    !tx_bit_strobe |=> (!tx_out_valid && !tx_hdlc_take && $stable(tx_out_bit)))
    else $error("transmit output moved without a strobe");

  AST_TX_OFF_NO_TAKE: assert property (@(posedge clock) disable iff (!rst_n)
    !tx_link_routing_control[HTR_ENABLE_BIT] |=> !tx_hdlc_take)
    else $error("hdlc bit taken while transmit disabled");

  AST_TX_SA_ONLY_SLOT0: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_bit_strobe && tx_link_routing_control[7:6] == 2'b10
     && (tx_slot != HTR_SA_SLOT || !tx_nfas_frame))
    |=> (!tx_hdlc_take && tx_out_bit == $past(tx_framer_bit)))
    else $error("transmit sa mode used a bit outside the sa positions");

  AST_TX_SA_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_bit_strobe && tx_link_routing_control[7:6] == 2'b10 && tx_slot == 5'h00
     && tx_nfas_frame && tx_bit_pos == 3'h4 && !tx_link_routing_control[3])
    |=> (!tx_hdlc_take && tx_out_bit == $past(tx_framer_bit)))
    else $error("disabled sa5 carried hdlc data");

  AST_TX_BLOCK_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_bit_strobe && tx_link_routing_control[7:5] == 3'b111
     && !tx_channel_block_map[tx_slot])
    |=> (!tx_hdlc_take && tx_out_bit == $past(tx_framer_bit)))
    else $error("unmapped transmit channel carried hdlc data");
endmodule
`default_nettype wire

// >>> bench/htr_far_model.sv
// hdlc controller side model: offers transmit bits, collects receive bits
`timescale 1ns/1ps
`default_nettype none
module htr_far_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tx_hdlc_take,
  output logic tx_hdlc_bit,
  input wire logic rx_hdlc_valid,
  input wire logic rx_hdlc_bit
);
  logic [7:0] pattern;
  logic [7:0] rx_shift;
  int unsigned rx_count;
  // pattern rotates on each take, so a missed or extra take shows up as a wrong bit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pattern <= 8'h6d;
      rx_shift <= 8'h00;
      rx_count <= 0;
    end else begin
      if (tx_hdlc_take) begin
        pattern <= {pattern[6:0], pattern[7]};
      end
      if (rx_hdlc_valid) begin
        rx_shift <= {rx_shift[6:0], rx_hdlc_bit};
        rx_count <= rx_count + 1;
      end
    end
  end
  assign tx_hdlc_bit = pattern[7];
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the hdlc timeslot routing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module testbench;
  import htr_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [4:0] rx_control_two_sa = 5'h00;
  logic [31:0] rx_channel_block_map = 32'h0000_0000, tx_channel_block_map = 32'h0000_0000;
  logic tx_bit_strobe = 1'b0, tx_nfas_frame = 1'b0, tx_framer_bit = 1'b0;
  logic [4:0] tx_slot = 5'h00, rx_slot = 5'h00;
  logic [2:0] tx_bit_pos = 3'h0, rx_bit_pos = 3'h0;
  logic rx_bit_strobe = 1'b0, rx_nfas_frame = 1'b0, rx_line_bit = 1'b0;
  logic tx_hdlc_bit, tx_out_bit, tx_out_valid, tx_hdlc_take, rx_hdlc_bit, rx_hdlc_valid;
  int num_errors = 0;
  int n_tests = 0;
  always #20 clock = ~clock;
  htr_top u_dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_control_two_sa(rx_control_two_sa), .rx_channel_block_map(rx_channel_block_map),
    .tx_channel_block_map(tx_channel_block_map), .tx_bit_strobe(tx_bit_strobe),
    .tx_slot(tx_slot), .tx_bit_pos(tx_bit_pos), .tx_nfas_frame(tx_nfas_frame),
    .tx_framer_bit(tx_framer_bit), .tx_hdlc_bit(tx_hdlc_bit), .tx_out_bit(tx_out_bit),
    .tx_out_valid(tx_out_valid), .tx_hdlc_take(tx_hdlc_take), .rx_bit_strobe(rx_bit_strobe),
    .rx_slot(rx_slot), .rx_bit_pos(rx_bit_pos), .rx_nfas_frame(rx_nfas_frame),
    .rx_line_bit(rx_line_bit), .rx_hdlc_bit(rx_hdlc_bit), .rx_hdlc_valid(rx_hdlc_valid));
  htr_far_model u_far (.clock(clock), .arst_n(arst_n), .tx_hdlc_take(tx_hdlc_take),
    .tx_hdlc_bit(tx_hdlc_bit), .rx_hdlc_valid(rx_hdlc_valid), .rx_hdlc_bit(rx_hdlc_bit));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask
  // unselected bits must pass the framer bit, which is made the inverse of the hdlc bit
  task automatic txb(input logic [4:0] s, input logic [2:0] p, input logic nf, input logic tk);
    logic hb;
    // a take from the call before rotates the far side on the next edge; sample after it
    @(posedge clock);
    @(posedge clock);
    hb = tx_hdlc_bit;
    tx_bit_strobe <= 1'b1;
    tx_slot <= s;
    tx_bit_pos <= p;
    tx_nfas_frame <= nf;
    tx_framer_bit <= ~hb;
    @(posedge clock);
    tx_bit_strobe <= 1'b0;
    #1;
    `CHK(tx_out_valid, 1'b1)
    `CHK(tx_hdlc_take, tk)
    `CHK(tx_out_bit, tk ? hb : ~hb)
  endtask
  task automatic rxb(input logic [4:0] s, input logic [2:0] p, input logic nf, input logic v);
    @(posedge clock);
    rx_bit_strobe <= 1'b1;
    rx_slot <= s;
    rx_bit_pos <= p;
    rx_nfas_frame <= nf;
    rx_line_bit <= ~rx_hdlc_bit;
    @(posedge clock);
    rx_bit_strobe <= 1'b0;
    #1;
    `CHK(rx_hdlc_valid, v)
    if (v) `CHK(rx_hdlc_bit, rx_line_bit)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 4000);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      rd(8'hb8 + 8'(i), 8'h00);
      wr(8'hb8 + 8'(i), 8'h5a ^ 8'(i));
      rd(8'hb8 + 8'(i), 8'h5a ^ 8'(i));
    end
    wr(8'hb7, 8'hff);
    rd(8'hb7, HTR_UNMAPPED_READ);
    $display("test registers done");
    wr(8'hbb, 8'h00);
    wr(8'hba, 8'h47);
    txb(5'd7, 3'h1, 1'b0, 1'b0);
    txb(5'd0, 3'h3, 1'b1, 1'b0);
    wr(8'hba, 8'h90);
    txb(5'd0, 3'h3, 1'b1, 1'b1);
    txb(5'd0, 3'h4, 1'b1, 1'b0);
    txb(5'd0, 3'h3, 1'b0, 1'b0);
    wr(8'hba, 8'h81);
    txb(5'd0, 3'h7, 1'b1, 1'b1);
    $display("test tx sa done");
    wr(8'hba, 8'hc7);
    wr(8'hbb, 8'h04);
    txb(5'd7, 3'h1, 1'b0, 1'b1);
    txb(5'd7, 3'h2, 1'b0, 1'b0);
    txb(5'd8, 3'h1, 1'b0, 1'b0);
    tx_channel_block_map <= 32'h4000_0008;
    wr(8'hba, 8'he7);
    txb(5'd30, 3'h0, 1'b0, 1'b1);
    txb(5'd3, 3'h7, 1'b0, 1'b1);
    txb(5'd7, 3'h1, 1'b0, 1'b0);
    $display("test tx ds0 done");
    rx_control_two_sa <= 5'h01;
    wr(8'hb8, 8'h10);
    rxb(5'd0, 3'h7, 1'b1, 1'b1);
    rxb(5'd0, 3'h3, 1'b1, 1'b0);
    wr(8'hb8, 8'h90);
    rxb(5'd0, 3'h3, 1'b1, 1'b1);
    rxb(5'd0, 3'h7, 1'b1, 1'b0);
    wr(8'hb8, 8'hc9);
    wr(8'hb9, 8'h80);
    rxb(5'd9, 3'h0, 1'b0, 1'b1);
    rxb(5'd9, 3'h7, 1'b0, 1'b0);
    rxb(5'd10, 3'h0, 1'b0, 1'b0);
    rx_channel_block_map <= 32'h0000_0020;
    wr(8'hb8, 8'he0);
    rxb(5'd5, 3'h0, 1'b0, 1'b1);
    rxb(5'd5, 3'h7, 1'b0, 1'b0);
    `CHK(u_far.rx_count, 32'd4)
    `CHK(u_far.rx_shift, 8'h0a)
    $display("test rx done");
    close_out();
  end
endmodule
`default_nettype wire
